/* File: verilog/fr_pkg.sv */
package fr_pkg;

	// ------------------------------------------------------------
	// Kinds of transfer and link phases
	// ------------------------------------------------------------
	typedef enum logic [2:0] {K_DO, K_DIO, K_QO, K_QIO, K_RSTQ, K_RSTD} fr_kind_t;
	typedef enum logic [2:0] {
		PH_IDLE, PH_CMD, PH_ADDR, PH_MODE, PH_DUMMY, PH_DATA, PH_IGN
	} fr_phase_t;

	// ------------------------------------------------------------
	// Opcodes and mode byte
	// ------------------------------------------------------------
	localparam logic [7:0] OP_DO = 8'h3b;
	localparam logic [7:0] OP_DIO = 8'hbb;
	localparam logic [7:0] OP_QO = 8'h6b;
	localparam logic [7:0] OP_QIO = 8'heb;
	localparam logic [7:0] OP_RST = 8'hff;
	localparam logic [1:0] SKIP_PAIR = 2'h2;
	localparam int SKIP_HI = 5;
	localparam int SKIP_LO = 4;

	// ------------------------------------------------------------
	// Sizes, counts and reset values
	// ------------------------------------------------------------
	localparam int MEM_AW = 19;
	localparam int ADDR_BITS = 24;
	localparam int MODE_BITS = 8;
	localparam logic [5:0] CMD_CLKS = 6'h08;
	localparam logic [5:0] DUMMY_CLKS = 6'h08;
	localparam logic [5:0] QIO_DUMMY_CLKS = 6'h04;
	localparam logic [5:0] RSTQ_CLKS = 6'h08;
	localparam logic [5:0] RSTD_CLKS = 6'h10;
	localparam logic [5:0] PIN_IDLE = 6'h1f;
	localparam logic [3:0] LANES_OFF = 4'hf;
	localparam int HALF_CYC_DEF = 12;

	// ------------------------------------------------------------
	// Phase helpers, all but op_of shared by both ends
	// ------------------------------------------------------------
	function automatic logic [2:0] addr_w(fr_kind_t k);
		case (k)
			K_DIO: return 3'h2;
			K_QIO: return 3'h4;
			default: return 3'h1;
		endcase
	endfunction

	function automatic logic [2:0] data_w(fr_kind_t k);
		return (k == K_QO || k == K_QIO) ? 3'h4 : 3'h2;
	endfunction

	function automatic logic [5:0] ph_len(fr_phase_t p, fr_kind_t k);
		case (p)
			PH_CMD: return CMD_CLKS;
			PH_ADDR: return 6'(ADDR_BITS / int'(addr_w(k)));
			PH_MODE: return 6'(MODE_BITS / int'(addr_w(k)));
			PH_DUMMY: return (k == K_QIO) ? QIO_DUMMY_CLKS : DUMMY_CLKS;
			PH_IGN: return (k == K_RSTD) ? RSTD_CLKS : RSTQ_CLKS;
			default: return 6'h00;
		endcase
	endfunction

	function automatic fr_phase_t ph_after(fr_phase_t p, fr_kind_t k);
		case (p)
			PH_CMD: return PH_ADDR;
			PH_ADDR: return (k == K_DIO || k == K_QIO) ? PH_MODE : PH_DUMMY;
			PH_MODE: return (k == K_QIO) ? PH_DUMMY : PH_DATA;
			PH_DUMMY: return PH_DATA;
			default: return p;
		endcase
	endfunction

	function automatic logic [7:0] op_of(fr_kind_t k);
		case (k)
			K_DIO: return OP_DIO;
			K_QO: return OP_QO;
			K_QIO: return OP_QIO;
			default: return OP_DO;
		endcase
	endfunction

	function automatic logic [3:0] lane_mask(logic [2:0] w);
		case (w)
			3'h4: return 4'hf;
			3'h2: return 4'h3;
			default: return 4'h1;
		endcase
	endfunction

	// First bit of a slice goes on the highest lane in use
	function automatic logic [3:0] top_lanes(logic [3:0] top, logic [2:0] w);
		case (w)
			3'h4: return top;
			3'h2: return {2'h0, top[3:2]};
			default: return {3'h0, top[3]};
		endcase
	endfunction

	function automatic logic [23:0] shift_in(logic [23:0] sh, logic [3:0] in, logic [2:0] w);
		case (w)
			3'h4: return {sh[19:0], in};
			3'h2: return {sh[21:0], in[1:0]};
			default: return {sh[22:0], in[0]};
		endcase
	endfunction

endpackage

/* File: verilog/fr_spi_if.sv */
interface fr_spi_if;
	// Lane 0 is the host-to-device line, lane 1 the device-to-host line
	logic sclk;
	logic cs_n;
	logic [3:0] dev_o;
	logic [3:0] dev_oe_n;
	logic [3:0] host_o;
	logic [3:0] host_oe_n;
	wire [3:0] io;

	// Wire level; an undriven lane floats high
	assign io = (~dev_oe_n & dev_o) | (~host_oe_n & host_o) | (dev_oe_n & host_oe_n);

	modport dev (input sclk, input cs_n, input io, output dev_o, output dev_oe_n);
	modport host (output sclk, output cs_n, input io, output host_o, output host_oe_n);
endinterface

/* File: verilog/fr_flash_dev.sv */
module fr_flash_dev import fr_pkg::*; #(
	parameter int AW = MEM_AW
) (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// Link
	fr_spi_if.dev spi,
	// Array read port
	output logic [AW-1:0] rd_addr_o,
	input wire logic [7:0] rd_data_i,
	// Configuration and status
	input wire logic quad_lane_enable_i,
	output logic cont_dual_o,
	output logic cont_quad_o,
	output logic reading_o
);

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic [5:0] pin_s1_reg;
	logic [5:0] pin_s2_reg;
	logic [5:0] pin_s3_reg;
	logic [5:0] pin_reg;
	logic [5:0] pin_next;

	// A pin changes once the second and third stages agree
	assign pin_next = (pin_s2_reg & pin_s3_reg) | (pin_reg & (pin_s2_reg | pin_s3_reg));

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			pin_s1_reg <= PIN_IDLE;
			pin_s2_reg <= PIN_IDLE;
			pin_s3_reg <= PIN_IDLE;
			pin_reg <= PIN_IDLE;
		end else begin
			pin_s1_reg <= {spi.sclk, spi.cs_n, spi.io};
			pin_s2_reg <= pin_s1_reg;
			pin_s3_reg <= pin_s2_reg;
			pin_reg <= pin_next;
		end
	end

	wire sclk_rise = pin_next[5] & ~pin_reg[5];
	wire sclk_fall = ~pin_next[5] & pin_reg[5];
	wire cs_idle = pin_next[4];
	wire [3:0] lanes_in = pin_next[3:0];

	// ------------------------------------------------------------
	// Sequencer state
	// ------------------------------------------------------------
	fr_phase_t ph_reg;
	fr_phase_t ph_next;
	fr_kind_t kind_reg;
	fr_kind_t kind_next;
	logic [5:0] cnt_reg;
	logic [5:0] cnt_next;
	logic [23:0] sh_reg;
	logic [23:0] sh_next;
	logic [AW-1:0] addr_reg;
	logic [AW-1:0] addr_next;
	logic [7:0] ob_reg;
	logic [7:0] ob_next;
	logic [1:0] sl_reg;
	logic [1:0] sl_next;
	logic [3:0] lane_reg;
	logic [3:0] lane_next;
	logic [3:0] oe_n_reg;
	logic [3:0] oe_n_next;
	logic cdual_reg;
	logic cdual_next;
	logic cquad_reg;
	logic cquad_next;

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	wire [2:0] in_w = (ph_reg == PH_CMD) ? 3'h1 : addr_w(kind_reg);
	wire [2:0] out_w = data_w(kind_reg);
	wire [23:0] sh_shift = shift_in(sh_reg, lanes_in, in_w);
	wire phase_end = (cnt_reg == ph_len(ph_reg, kind_reg) - 6'h01);
	wire shifting = sclk_rise && ph_reg != PH_DATA && ph_reg != PH_IGN;
	wire skip_hit = (sh_shift[SKIP_HI:SKIP_LO] == SKIP_PAIR);
	wire [7:0] drv_byte = (sl_reg == 2'h0) ? rd_data_i : ob_reg;
	wire [1:0] sl_last = (out_w == 3'h4) ? 2'h1 : 2'h3;
	wire [AW-1:0] addr_inc = (addr_reg == {AW{1'b1}}) ? '0 : addr_reg + 1'b1;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		ph_next = ph_reg;
		kind_next = kind_reg;
		cnt_next = cnt_reg;
		sh_next = sh_reg;
		addr_next = addr_reg;
		ob_next = ob_reg;
		sl_next = sl_reg;
		lane_next = lane_reg;
		oe_n_next = oe_n_reg;
		cdual_next = cdual_reg;
		cquad_next = cquad_reg;
		if (cs_idle) begin
			ph_next = PH_IDLE;
			oe_n_next = LANES_OFF;
			cnt_next = 6'h00;
			sl_next = 2'h0;
		end else if (ph_reg == PH_IDLE) begin
			cnt_next = 6'h00;
			if (cquad_reg && quad_lane_enable_i) begin
				ph_next = PH_ADDR;
				kind_next = K_QIO;
			end else if (cdual_reg) begin
				ph_next = PH_ADDR;
				kind_next = K_DIO;
			end else begin
				ph_next = PH_CMD;
			end
		end else if (shifting) begin
			sh_next = sh_shift;
			cnt_next = cnt_reg + 6'h01;
			if (phase_end) begin
				cnt_next = 6'h00;
				ph_next = ph_after(ph_reg, kind_reg);
				case (ph_reg)
					PH_CMD: begin
						ph_next = PH_ADDR;
						case (sh_shift[7:0])
							OP_DO: kind_next = K_DO;
							OP_DIO: kind_next = K_DIO;
							OP_QO: begin
								kind_next = K_QO;
								if (!quad_lane_enable_i) begin
									ph_next = PH_IGN;
								end
							end
							OP_QIO: begin
								kind_next = K_QIO;
								if (!quad_lane_enable_i) begin
									ph_next = PH_IGN;
								end
							end
							OP_RST: begin
								cdual_next = 1'b0;
								cquad_next = 1'b0;
								ph_next = PH_IGN;
							end
							default: ph_next = PH_IGN;
						endcase
					end
					PH_ADDR: addr_next = sh_shift[AW-1:0];
					PH_MODE: begin
						// Only the pair decides; an all-ones reset lands here too
						cdual_next = (kind_reg == K_DIO) && skip_hit;
						cquad_next = (kind_reg == K_QIO) && skip_hit;
					end
					default: ;
				endcase
			end
		end else if (sclk_fall && ph_reg == PH_DATA) begin
			lane_next = top_lanes(drv_byte[7:4], out_w);
			ob_next = (out_w == 3'h4) ? {drv_byte[3:0], 4'h0} : {drv_byte[5:0], 2'h0};
			oe_n_next = ~lane_mask(out_w);
			sl_next = (sl_reg == sl_last) ? 2'h0 : sl_reg + 2'h1;
			if (sl_reg == 2'h0) begin
				addr_next = addr_inc;
			end
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			ph_reg <= PH_IDLE;
			kind_reg <= K_DO;
			cnt_reg <= 6'h00;
			sh_reg <= 24'h000000;
			addr_reg <= '0;
			ob_reg <= 8'h00;
			sl_reg <= 2'h0;
			lane_reg <= 4'h0;
			oe_n_reg <= LANES_OFF;
			cdual_reg <= 1'b0;
			cquad_reg <= 1'b0;
			reading_o <= 1'b0;
		end else begin
			ph_reg <= ph_next;
			kind_reg <= kind_next;
			cnt_reg <= cnt_next;
			sh_reg <= sh_next;
			addr_reg <= addr_next;
			ob_reg <= ob_next;
			sl_reg <= sl_next;
			lane_reg <= lane_next;
			oe_n_reg <= oe_n_next;
			cdual_reg <= cdual_next;
			cquad_reg <= cquad_next;
			reading_o <= (ph_next == PH_DATA);
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign rd_addr_o = addr_reg;
	assign cont_dual_o = cdual_reg;
	assign cont_quad_o = cquad_reg;
	assign spi.dev_o = lane_reg;
	assign spi.dev_oe_n = oe_n_reg;

endmodule

/* File: verilog/fr_flash_host.sv */
module fr_flash_host import fr_pkg::*; #(
	parameter int HALF_CYC = HALF_CYC_DEF
) (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// Command
	input wire logic start_i,
	input wire fr_kind_t kind_i,
	input wire logic skip_op_i,
	input wire logic [23:0] addr_i,
	input wire logic [7:0] mode_i,
	input wire logic [15:0] nbytes_i,
	// Status and data
	output logic busy_o,
	output logic done_o,
	output logic rx_valid_o,
	output logic [7:0] rx_data_o,
	// Link
	fr_spi_if.host spi
);

	typedef enum {H_IDLE, H_LO, H_HI, H_GAP} fr_hstate_t;

	// ------------------------------------------------------------
	// Lane input synchroniser
	// ------------------------------------------------------------
	logic [3:0] in_s1_reg;
	logic [3:0] in_s2_reg;
	logic [3:0] in_s3_reg;
	logic [3:0] in_reg;
	logic [3:0] in_next;

	assign in_next = (in_s2_reg & in_s3_reg) | (in_reg & (in_s2_reg | in_s3_reg));

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			in_s1_reg <= LANES_OFF;
			in_s2_reg <= LANES_OFF;
			in_s3_reg <= LANES_OFF;
			in_reg <= LANES_OFF;
		end else begin
			in_s1_reg <= spi.io;
			in_s2_reg <= in_s1_reg;
			in_s3_reg <= in_s2_reg;
			in_reg <= in_next;
		end
	end

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	fr_hstate_t st_reg;
	fr_phase_t ph_reg;
	fr_kind_t kind_reg;
	logic [15:0] div_reg;
	logic [5:0] cnt_reg;
	logic [39:0] tx_reg;
	logic [7:0] rx_reg;
	logic [1:0] sl_reg;
	logic [15:0] left_reg;
	logic sclk_reg;
	logic cs_n_reg;
	logic [3:0] lane_reg;
	logic [3:0] oe_n_reg;

	// ------------------------------------------------------------
	// Phase advance at each falling edge
	// ------------------------------------------------------------
	function automatic logic [2:0] host_w(fr_phase_t p, fr_kind_t k);
		case (p)
			PH_ADDR, PH_MODE: return addr_w(k);
			PH_DATA: return data_w(k);
			PH_IGN: return 3'h4;
			default: return 3'h1;
		endcase
	endfunction

	// Lanes and enables for one clock; released before data
	function automatic logic [7:0] drive(fr_phase_t p, fr_kind_t k, logic [3:0] top);
		logic [2:0] w;
		w = host_w(p, k);
		if (p == PH_DATA || (p == PH_DUMMY && k == K_QIO)) begin
			return {LANES_OFF, 4'h0};
		end
		return {~lane_mask(w), top_lanes(top, w)};
	endfunction

	wire tick = (div_reg == 16'(HALF_CYC - 1));
	wire is_rst = (kind_i == K_RSTQ || kind_i == K_RSTD);
	wire [39:0] ld_tx = is_rst ? {40{1'b1}} :
		skip_op_i ? {addr_i, mode_i, 8'h00} : {op_of(kind_i), addr_i, mode_i};
	wire fr_phase_t ld_ph = is_rst ? PH_IGN : skip_op_i ? PH_ADDR : PH_CMD;
	wire last = (cnt_reg == ph_len(ph_reg, kind_reg) - 6'h01);
	wire adv = last && ph_reg != PH_DATA && ph_reg != PH_IGN;
	wire fr_phase_t ph_adv = adv ? ph_after(ph_reg, kind_reg) : ph_reg;
	// All-ones frames keep their ones for the full eight (quad) or sixteen (dual) clocks
	wire [39:0] tx_adv = (ph_reg == PH_IGN) ? tx_reg : tx_reg << host_w(ph_reg, kind_reg);
	wire fin = (ph_reg == PH_IGN && last) || (ph_adv == PH_DATA && left_reg == 16'h0000);
	wire [23:0] rx_full = shift_in({16'h0000, rx_reg}, in_next, data_w(kind_reg));
	wire [7:0] rx_shift = rx_full[7:0];
	wire [1:0] sl_last = (data_w(kind_reg) == 3'h4) ? 2'h1 : 2'h3;
	wire [7:0] ld_drv = drive(ld_ph, kind_i, ld_tx[39:36]);
	wire [7:0] adv_drv = drive(ph_adv, kind_reg, tx_adv[39:36]);

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			st_reg <= H_IDLE;
			ph_reg <= PH_IDLE;
			kind_reg <= K_DO;
			div_reg <= 16'h0000;
			cnt_reg <= 6'h00;
			tx_reg <= 40'h0000000000;
			rx_reg <= 8'h00;
			sl_reg <= 2'h0;
			left_reg <= 16'h0000;
			sclk_reg <= 1'b0;
			cs_n_reg <= 1'b1;
			lane_reg <= 4'h0;
			oe_n_reg <= LANES_OFF;
			busy_o <= 1'b0;
			done_o <= 1'b0;
			rx_valid_o <= 1'b0;
			rx_data_o <= 8'h00;
		end else begin
			done_o <= 1'b0;
			rx_valid_o <= 1'b0;
			div_reg <= (tick || st_reg == H_IDLE) ? 16'h0000 : div_reg + 16'h0001;
			case (st_reg)
				H_IDLE: begin
					if (start_i) begin
						st_reg <= H_LO;
						busy_o <= 1'b1;
						cs_n_reg <= 1'b0;
						kind_reg <= kind_i;
						ph_reg <= ld_ph;
						tx_reg <= ld_tx;
						cnt_reg <= 6'h00;
						sl_reg <= 2'h0;
						left_reg <= nbytes_i;
						{oe_n_reg, lane_reg} <= ld_drv;
					end
				end
				H_LO: begin
					if (tick) begin
						st_reg <= H_HI;
						sclk_reg <= 1'b1;
						if (ph_reg == PH_DATA) begin
							rx_reg <= rx_shift;
							sl_reg <= (sl_reg == sl_last) ? 2'h0 : sl_reg + 2'h1;
							if (sl_reg == sl_last) begin
								rx_valid_o <= 1'b1;
								rx_data_o <= rx_shift;
								left_reg <= left_reg - 16'h0001;
							end
						end
					end
				end
				H_HI: begin
					if (tick) begin
						sclk_reg <= 1'b0;
						if (fin) begin
							st_reg <= H_GAP;
							cs_n_reg <= 1'b1;
							oe_n_reg <= LANES_OFF;
							done_o <= 1'b1;
						end else begin
							st_reg <= H_LO;
							ph_reg <= ph_adv;
							cnt_reg <= adv ? 6'h00 : cnt_reg + 6'h01;
							tx_reg <= tx_adv;
							{oe_n_reg, lane_reg} <= adv_drv;
						end
					end
				end
				H_GAP: begin
					if (tick) begin
						st_reg <= H_IDLE;
						busy_o <= 1'b0;
					end
				end
				default: st_reg <= H_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign spi.sclk = sclk_reg;
	assign spi.cs_n = cs_n_reg;
	assign spi.host_o = lane_reg;
	assign spi.host_oe_n = oe_n_reg;

endmodule

/* File: verif/fr_props.sv */
module fr_props (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// Link
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic [3:0] dev_o,
	input wire logic [3:0] dev_oe_n,
	input wire logic [3:0] host_o,
	input wire logic [3:0] host_oe_n,
	input wire logic [3:0] io
);
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (rst_i);

	// ------------------------------------------------------------
	// Serial clock rises since select fell
	// ------------------------------------------------------------
	logic sclk_q;
	logic [5:0] rise_cnt;

	always_ff @(posedge core_clk_i) begin
		sclk_q <= sclk;
		if (rst_i || cs_n) begin
			rise_cnt <= 6'h00;
		end else if (sclk && !sclk_q && rise_cnt != 6'h3f) begin
			rise_cnt <= rise_cnt + 6'h01;
		end
	end

	// ------------------------------------------------------------
	// Device turns its lanes on
	// ------------------------------------------------------------
	sequence s_first_dual;
		$past(dev_oe_n) == 4'hf && dev_oe_n == 4'hc;
	endsequence

	sequence s_first_quad;
		$past(dev_oe_n) == 4'hf && dev_oe_n == 4'h0;
	endsequence

	a_dual_start_count: assert property (s_first_dual |-> rise_cnt inside {6'h28, 6'h18, 6'h10})
		else $error("dual data began after a wrong clock count");
	a_quad_start_count: assert property (s_first_quad |-> rise_cnt inside {6'h28, 6'h14, 6'h0c})
		else $error("quad data began after a wrong clock count");
	a_release_on_cs: assert property ($rose(cs_n) |-> ##[0:8] dev_oe_n == 4'hf)
		else $error("device lanes not released after select rose");
	a_idle_released: assert property (cs_n [*8] |-> dev_oe_n == 4'hf)
		else $error("device drives a lane while deselected");
	a_lane_width: assert property (dev_oe_n inside {4'hf, 4'hc, 4'h0})
		else $error("device drives an odd set of lanes");
	a_no_contention: assert property ((dev_oe_n | host_oe_n) == 4'hf)
		else $error("host and device drive one lane together");
	a_slice_steady: assert property ((sclk && $past(sclk) && dev_oe_n != 4'hf
		&& $past(dev_oe_n) != 4'hf) |-> $stable(dev_o))
		else $error("device data changed while serial clock high");
	a_drive_on_low: assert property ((dev_oe_n != 4'hf && $past(dev_oe_n) == 4'hf)
		|-> !sclk && !cs_n)
		else $error("device began driving outside a low clock phase");
endmodule

/* File: verif/multi_lane_flash_read_sequencer_tb.sv */
module multi_lane_flash_read_sequencer_tb import fr_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int HALF = 10;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic start = 1'b0;
	fr_kind_t kind = K_DO;
	logic skip = 1'b0;
	logic [23:0] addr = 24'h000000;
	logic [7:0] mode = 8'h00;
	logic [15:0] nbytes = 16'h0000;
	logic qe = 1'b1;
	logic busy, done, rx_valid, cont_dual, cont_quad, reading;
	logic [7:0] rx_data;
	logic [MEM_AW-1:0] rd_addr;
	logic [7:0] rd_data;
	int failures = 0;
	int samples_checked = 0;
	int low_cyc;
	int full_cyc;
	logic saw_read;
	logic [7:0] rx_q[$];

	always #20 core_clk = ~core_clk;

	function automatic logic [7:0] mem_byte(input logic [MEM_AW-1:0] a);
		return a[7:0] ^ {1'b0, a[18:12]};
	endfunction
	assign rd_data = mem_byte(rd_addr);

	fr_spi_if spi_bus();
	fr_flash_dev #(.AW(MEM_AW)) i_fr_flash_dev (.core_clk_i(core_clk), .rst_i(rst), .spi(spi_bus),
		.rd_addr_o(rd_addr), .rd_data_i(rd_data), .quad_lane_enable_i(qe),
		.cont_dual_o(cont_dual), .cont_quad_o(cont_quad), .reading_o(reading));
	fr_flash_host #(.HALF_CYC(HALF)) i_fr_flash_host (.core_clk_i(core_clk), .rst_i(rst),
		.start_i(start), .kind_i(kind), .skip_op_i(skip), .addr_i(addr), .mode_i(mode),
		.nbytes_i(nbytes), .busy_o(busy), .done_o(done), .rx_valid_o(rx_valid),
		.rx_data_o(rx_data), .spi(spi_bus));
	fr_props u_props (.core_clk_i(core_clk), .rst_i(rst), .sclk(spi_bus.sclk),
		.cs_n(spi_bus.cs_n), .dev_o(spi_bus.dev_o), .dev_oe_n(spi_bus.dev_oe_n),
		.host_o(spi_bus.host_o), .host_oe_n(spi_bus.host_oe_n), .io(spi_bus.io));

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %0t ns: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	task automatic run(input fr_kind_t k, input logic s, input logic [23:0] a,
		input logic [7:0] m, input logic [15:0] n);
		int guard;
		guard = 0;
		low_cyc = 0;
		saw_read = 1'b0;
		rx_q.delete();
		@(posedge core_clk);
		start <= 1'b1;
		kind <= k;
		skip <= s;
		addr <= a;
		mode <= m;
		nbytes <= n;
		@(posedge core_clk);
		start <= 1'b0;
		do begin
			@(negedge core_clk);
			guard++;
			if (rx_valid === 1'b1) rx_q.push_back(rx_data);
			if (spi_bus.cs_n === 1'b0) low_cyc++;
			if (reading === 1'b1) saw_read = 1'b1;
		end while (done !== 1'b1 && guard < 20000);
		while (busy !== 1'b0 && guard < 20000) begin
			@(negedge core_clk);
			guard++;
		end
		check(guard < 20000, 1'b1);
		check(spi_bus.dev_oe_n, 4'hf);
		check(reading, 1'b0);
	endtask

	task automatic expect_stream(input logic [23:0] a, input int n);
		logic [MEM_AW-1:0] x;
		check(rx_q.size(), n);
		check(saw_read, 1'b1);
		for (int i = 0; i < rx_q.size(); i++) begin
			x = a[MEM_AW-1:0] + MEM_AW'(i);
			check(rx_q[i], mem_byte(x));
		end
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_output_reads();
		run(K_DO, 1'b0, 24'h07fffe, 8'h00, 16'h0004);
		expect_stream(24'h07fffe, 4);
		run(K_QO, 1'b0, 24'h000123, 8'h00, 16'h0003);
		expect_stream(24'h000123, 3);
		run(K_DO, 1'b0, 24'h000005, 8'h00, 16'h0000);
		check(rx_q.size(), 0);
	endtask

	task automatic t_quad_refused();
		@(posedge core_clk);
		qe <= 1'b0;
		run(K_QO, 1'b0, 24'h000010, 8'h00, 16'h0002);
		check({rx_q[0], rx_q[1]}, 16'hffff);
		check(saw_read, 1'b0);
		run(K_QIO, 1'b0, 24'h000010, 8'h20, 16'h0002);
		check({rx_q[0], rx_q[1]}, 16'hffff);
		check(saw_read, 1'b0);
		check(cont_quad, 1'b0);
		@(posedge core_clk);
		qe <= 1'b1;
	endtask

	task automatic t_dual_cont();
		run(K_DIO, 1'b0, 24'h000200, 8'h2f, 16'h0002);
		expect_stream(24'h000200, 2);
		check(cont_dual, 1'b1);
		full_cyc = low_cyc;
		run(K_DIO, 1'b1, 24'h040000, 8'he0, 16'h0002);
		expect_stream(24'h040000, 2);
		check(low_cyc, full_cyc - 16 * HALF);
		check(cont_dual, 1'b1);
		run(K_DIO, 1'b1, 24'h000300, 8'h1a, 16'h0001);
		expect_stream(24'h000300, 1);
		check(cont_dual, 1'b0);
		run(K_DIO, 1'b0, 24'h000310, 8'h00, 16'h0001);
		expect_stream(24'h000310, 1);
	endtask

	task automatic t_quad_cont();
		run(K_QIO, 1'b0, 24'h012345, 8'h00, 16'h0002);
		expect_stream(24'h012345, 2);
		check(cont_quad, 1'b0);
		run(K_QIO, 1'b0, 24'h001000, 8'hac, 16'h0002);
		expect_stream(24'h001000, 2);
		check(cont_quad, 1'b1);
		full_cyc = low_cyc;
		run(K_QIO, 1'b1, 24'h07ffff, 8'ha0, 16'h0002);
		expect_stream(24'h07ffff, 2);
		check(low_cyc, full_cyc - 16 * HALF);
		run(K_RSTQ, 1'b0, 24'h000000, 8'h00, 16'h0000);
		check(cont_quad, 1'b0);
		run(K_QIO, 1'b0, 24'h000050, 8'h00, 16'h0001);
		expect_stream(24'h000050, 1);
		run(K_DIO, 1'b0, 24'h000060, 8'h20, 16'h0001);
		expect_stream(24'h000060, 1);
		check(cont_dual, 1'b1);
		run(K_RSTD, 1'b0, 24'h000000, 8'h00, 16'h0000);
		check(cont_dual, 1'b0);
	endtask

	// ------------------------------------------------------------
	// Run control
	// ------------------------------------------------------------
	task automatic finish_test();
		$display("TB: checks %0d, failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (6) @(posedge core_clk);
		rst <= 1'b0;
		t_output_reads();
		t_quad_refused();
		t_dual_cont();
		t_quad_cont();
		finish_test();
	end

	initial begin
		#2000000;
		failures++;
		finish_test();
	end
endmodule
